// file: inc/qsd_defs.svh
`ifndef QSD_DEFS_SVH
`define QSD_DEFS_SVH

// ****************************************************************
// Command identity and subcommand codes
// ****************************************************************
`define QSD_OPC_SEND_QUEUED 8'h64
`define QSD_SUB_LOG_WRITE 4'h2
`define QSD_SUB_HI 3
`define QSD_SUB_LO 0

// ****************************************************************
// Field positions in the command fields
// ****************************************************************
`define QSD_TAG_HI 7
`define QSD_TAG_LO 3
`define QSD_DEVHEAD_FIX_BIT 6

// ****************************************************************
// Error and status register layout and reset values
// ****************************************************************
`define QSD_ERR_ABT_BIT 2
`define QSD_ST_BSY_BIT 7
`define QSD_ST_RDY_BIT 6
`define QSD_ST_ERR_BIT 0
`define QSD_ERRF_RST 8'h00
`define QSD_STAT_RST 8'h40

`endif

// file: inc/qsd_pkg.sv
package qsd_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  localparam int QSD_TAG_W = 5;
  localparam int QSD_TAGS = 32;

  // Decoded queued log-page write, as handed to execution
  typedef struct packed {
    logic [QSD_TAG_W-1:0] tag;
    logic [15:0] count;
    logic [47:0] lba;
  } qsd_cmd_t;

  typedef enum logic [1:0] {
    qsd_idle,
    qsd_check,
    qsd_push,
    qsd_error
  } qsd_state_t;

endpackage : qsd_pkg

// file: inc/qsd_buf_if.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Carrier between decoder and its two-entry buffer
// ****************************************************************
interface qsd_buf_if #(
  parameter int WIDTH = 8
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport buffer (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface : qsd_buf_if

`default_nettype wire

// file: hdl/qsd_buf.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Small valid/ready buffer, holds words while the drain stalls
// ****************************************************************
module qsd_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  qsd_buf_if.buffer bif
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] used_ff;
  logic do_wr;
  logic do_rd;

  // Honest full and empty straight from the fill count
  assign bif.in_ready = (used_ff != FULL);
  assign bif.out_valid = (used_ff != '0);
  assign bif.out_data = mem_ff[rd_ptr_ff];
  assign do_wr = bif.in_valid && bif.in_ready;
  assign do_rd = bif.out_valid && bif.out_ready;

  // Storage, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= bif.in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      used_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        used_ff <= used_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        used_ff <= used_ff - 1'b1;
      end
    end
  end
endmodule : qsd_buf

`default_nettype wire

// file: hdl/qsd_send_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "qsd_defs.svh"

module qsd_send_decoder
  import qsd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feat_cur,
  input wire logic [7:0] cmd_feat_prev,
  input wire logic [7:0] cmd_cnt_cur,
  input wire logic [7:0] cmd_cnt_prev,
  input wire logic [7:0] cmd_secn_cur,
  input wire logic [7:0] cmd_secn_prev,
  input wire logic [7:0] cmd_cyll_cur,
  input wire logic [7:0] cmd_cyll_prev,
  input wire logic [7:0] cmd_cylh_cur,
  input wire logic [7:0] cmd_cylh_prev,
  input wire logic [7:0] cmd_devhead,
  output logic wlog_valid,
  input wire logic wlog_ready,
  output logic [QSD_TAG_W-1:0] wlog_tag,
  output logic [15:0] wlog_count,
  output logic [47:0] wlog_lba,
  input wire logic done_valid,
  input wire logic [QSD_TAG_W-1:0] done_tag,
  output logic sdb_valid,
  input wire logic sdb_ready,
  output logic [QSD_TAGS-1:0] sdb_act,
  output logic d2h_valid,
  input wire logic d2h_ready,
  output logic [7:0] d2h_error,
  output logic [7:0] d2h_status,
  output logic [7:0] command_error_flags,
  output logic [7:0] device_condition_flags
);

  // ****************************************************************
  // Captured command and decode
  // ****************************************************************
  qsd_state_t state_ff;
  qsd_state_t nxt_state;
  logic [7:0] feat_cur_ff;
  logic [7:0] feat_prev_ff;
  logic [7:0] cnt_cur_ff;
  logic [7:0] devhead_ff;
  logic [47:0] lba_ff;
  logic [QSD_TAGS-1:0] outstanding_ff;
  logic [QSD_TAGS-1:0] pending_ff;
  logic [7:0] errf_ff;
  logic [7:0] stat_ff;
  logic take;
  logic is_send;
  logic sub_log_write;
  logic devhead_ok;
  logic tag_free;
  logic accept_ok;
  logic push_done;
  logic err_done;
  logic sdb_take;
  logic [QSD_TAG_W-1:0] cmd_tag;
  logic [QSD_TAGS-1:0] done_mask;
  logic [QSD_TAGS-1:0] push_mask;
  qsd_cmd_t cmd_rec;

  qsd_buf_if #(.WIDTH($bits(qsd_cmd_t))) bif ();

  // Only one command is handled at a time; the rest wait on cmd_ready
  assign cmd_ready = (state_ff == qsd_idle);
  assign take = cmd_valid && cmd_ready;
  assign is_send = (cmd_opcode == `QSD_OPC_SEND_QUEUED);

  // Subcommand lives in the low nibble; upper bits are subcommand specific
  assign sub_log_write = (feat_cur_ff[`QSD_SUB_HI:`QSD_SUB_LO] == `QSD_SUB_LOG_WRITE);
  assign devhead_ok = devhead_ff[`QSD_DEVHEAD_FIX_BIT];
  assign cmd_tag = cnt_cur_ff[`QSD_TAG_HI:`QSD_TAG_LO];
  // A tag still in flight must not be reused
  assign tag_free = !outstanding_ff[cmd_tag];
  // Checks chosen by the decoded subcommand, not the opcode alone
  assign accept_ok = sub_log_write && devhead_ok && tag_free;

  // Decoded record toward execution
  assign cmd_rec.tag = cmd_tag;
  assign cmd_rec.count = {feat_prev_ff, feat_cur_ff};
  assign cmd_rec.lba = lba_ff;

  assign push_done = (state_ff == qsd_push) && bif.in_ready;
  assign err_done = (state_ff == qsd_error) && d2h_ready;
  assign sdb_take = sdb_valid && sdb_ready;
  assign done_mask = done_valid ? (QSD_TAGS'(1) << done_tag) : '0;
  assign push_mask = push_done ? (QSD_TAGS'(1) << cmd_tag) : '0;

  // ****************************************************************
  // Buffer toward execution
  // ****************************************************************
  assign bif.in_valid = (state_ff == qsd_push);
  assign bif.in_data = cmd_rec;
  assign bif.out_ready = wlog_ready;

  qsd_buf #(
    .WIDTH($bits(qsd_cmd_t)),
    .DEPTH(2)
  ) u_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .bif(bif)
  );

  // Buffer head is register-held, so these come from flip-flops
  assign wlog_valid = bif.out_valid;
  assign {wlog_tag, wlog_count, wlog_lba} = bif.out_data;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      qsd_idle: begin
        if (take && is_send) begin
          nxt_state = qsd_check;
        end
      end
      qsd_check: begin
        nxt_state = accept_ok ? qsd_push : qsd_error;
      end
      qsd_push: begin
        if (bif.in_ready) begin
          nxt_state = qsd_idle;
        end
      end
      qsd_error: begin
        if (d2h_ready) begin
          nxt_state = qsd_idle;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= qsd_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command field capture on take
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      feat_cur_ff <= '0;
      feat_prev_ff <= '0;
      cnt_cur_ff <= '0;
      devhead_ff <= '0;
      lba_ff <= '0;
    end else if (take && is_send) begin
      feat_cur_ff <= cmd_feat_cur;
      feat_prev_ff <= cmd_feat_prev;
      cnt_cur_ff <= cmd_cnt_cur;
      devhead_ff <= cmd_devhead;
      lba_ff <= {cmd_cylh_prev, cmd_cyll_prev, cmd_secn_prev,
                 cmd_cylh_cur, cmd_cyll_cur, cmd_secn_cur};
    end
  end

  // ****************************************************************
  // Error and status registers
  // ****************************************************************
  // Busy from take until acknowledged or reported; flags clear on next take
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      errf_ff <= `QSD_ERRF_RST;
      stat_ff <= `QSD_STAT_RST;
    end else begin
      if (take && is_send) begin
        errf_ff <= `QSD_ERRF_RST;
        stat_ff[`QSD_ST_ERR_BIT] <= 1'b0;
        stat_ff[`QSD_ST_BSY_BIT] <= 1'b1;
      end else if (state_ff == qsd_check && !accept_ok) begin
        errf_ff[`QSD_ERR_ABT_BIT] <= 1'b1;
        stat_ff[`QSD_ST_ERR_BIT] <= 1'b1;
      end else if (push_done || err_done) begin
        stat_ff[`QSD_ST_BSY_BIT] <= 1'b0;
      end
    end
  end

  assign command_error_flags = errf_ff;
  assign device_condition_flags = stat_ff;

  // Register frame for a rejected, still-busy command; shows busy cleared
  assign d2h_valid = (state_ff == qsd_error);
  assign d2h_error = errf_ff;
  assign d2h_status = {1'b0, stat_ff[`QSD_ST_BSY_BIT-1:0]};

  // ****************************************************************
  // Completion tracking
  // ****************************************************************
  // In-flight tags; a new set beats a same-cycle completion
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outstanding_ff <= '0;
    end else begin
      outstanding_ff <= (outstanding_ff & ~done_mask) | push_mask;
    end
  end

  // Completed tags gather until a notification frame takes them
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_ff <= '0;
    end else if (sdb_take) begin
      pending_ff <= done_mask;
    end else begin
      pending_ff <= pending_ff | done_mask;
    end
  end

  assign sdb_valid = |pending_ff;
  assign sdb_act = pending_ff;

endmodule : qsd_send_decoder

`default_nettype wire

// file: test/qsd_send_decoder_asserts.sv
`timescale 1ns/100ps
`default_nettype none

// ******************************
// Port checks of the decoder
// ******************************
module qsd_send_decoder_asserts
  import qsd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feat_cur,
  input wire logic done_valid,
  input wire logic [QSD_TAG_W-1:0] done_tag,
  input wire logic sdb_valid,
  input wire logic sdb_ready,
  input wire logic [QSD_TAGS-1:0] sdb_act,
  input wire logic d2h_valid,
  input wire logic d2h_ready,
  input wire logic [7:0] d2h_error,
  input wire logic [7:0] d2h_status,
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] device_condition_flags
);
  // One clock domain, so one default clocking
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_reject_sub: assert property (cmd_valid && cmd_ready && cmd_opcode == 8'h64 &&
    cmd_feat_cur[3:0] != 4'h2 |-> ##2 d2h_valid && d2h_error[2] && d2h_status[0])
    else $error("reserved subcommand not aborted");
  a_take_busy: assert property (cmd_valid && cmd_ready && cmd_opcode == 8'h64
    |=> device_condition_flags[7] && !cmd_ready) else $error("busy not raised on take");
  // A new command may be taken one cycle later, so busy is only judged in the first cycle
  a_foreign_drop: assert property (cmd_valid && cmd_ready && cmd_opcode != 8'h64
    |=> !device_condition_flags[7] && !d2h_valid ##1 !d2h_valid) else $error("foreign opcode acted on");
  a_done_act: assert property (done_valid |=> sdb_valid && sdb_act[$past(done_tag)])
    else $error("completed tag missing from frame");
  a_sdb_hold: assert property (sdb_valid && !sdb_ready && !done_valid
    |=> sdb_valid && $stable(sdb_act)) else $error("completion frame dropped");
  a_sdb_clear: assert property (sdb_valid && sdb_ready && !done_valid |=> !sdb_valid)
    else $error("completion bits kept after frame");
  a_d2h_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_error))
    else $error("error frame dropped");
  a_d2h_mirror: assert property (d2h_valid |-> d2h_error == command_error_flags &&
    d2h_status == {1'b0, device_condition_flags[6:0]}) else $error("error frame fields wrong");
  a_d2h_release: assert property (d2h_valid && d2h_ready
    |=> !d2h_valid && !device_condition_flags[7]) else $error("busy kept after error frame");
endmodule : qsd_send_decoder_asserts

`default_nettype wire

// file: test/qsd_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ******************************
// Host side of the command link
// ******************************
module qsd_host_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] stall,
  input wire logic sdb_valid,
  output logic sdb_ready,
  input wire logic d2h_valid,
  output logic d2h_ready,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [95:0] cmd_f
);
  logic [3:0] wait_ff;

  // Frame wait counter, shared by both frame kinds
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) wait_ff <= 4'h0;
    else if (!(sdb_valid || d2h_valid) || sdb_ready || d2h_ready) wait_ff <= 4'h0;
    else wait_ff <= wait_ff + 4'h1;
  end
  assign sdb_ready = sdb_valid && wait_ff >= stall;
  assign d2h_ready = d2h_valid && wait_ff >= stall;

  // Nothing offered before the bench asks
  initial begin
    cmd_valid = 1'b0;
    cmd_f = 96'h0;
  end

  // Hold fields until taken, then scramble them
  task automatic issue(input logic [7:0] opc, input logic [7:0] fc, input logic [7:0] cc,
                       input logic [7:0] dh, input logic [47:0] a);
    @(negedge core_clk);
    cmd_f = {opc, fc, 8'ha5, cc, 8'h3c, a[7:0], a[31:24], a[15:8], a[39:32], a[23:16], a[47:40], dh};
    cmd_valid = 1'b1;
    // No local limit; the bench watchdog catches a ready that never comes
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_f = ~cmd_f;
  endtask : issue
endmodule : qsd_host_model

`default_nettype wire

// file: test/qsd_send_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ******************************
// Decoder bench
// ******************************
module qsd_send_decoder_tb
  import qsd_pkg::*;
;
  typedef struct packed {logic [7:0] fc; logic [7:0] dh; logic [4:0] tg; logic ok;} qsd_row_t;
  qsd_row_t rows [3] = '{'{8'h12, 8'he0, 5'd31, 1'b1}, '{8'hf2, 8'h40, 5'd0, 1'b1}, '{8'h02, 8'h00, 5'd4, 1'b0}};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, cmd_ready, wlog_valid, sdb_valid, sdb_ready, d2h_valid, d2h_ready;
  logic wlog_ready = 1'b0;
  logic done_valid = 1'b0;
  logic [4:0] done_tag = 5'h0;
  logic [3:0] stall = 4'h0;
  logic [95:0] cmd_f;
  logic [4:0] wlog_tag;
  logic [15:0] wlog_count;
  logic [47:0] wlog_lba;
  logic [31:0] sdb_act;
  logic [7:0] d2h_error, d2h_status, cef, dcf;
  int mismatches = 0;
  int total_checks = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  qsd_send_decoder i_dut (.core_clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_opcode(cmd_f[95:88]),
    .cmd_feat_cur(cmd_f[87:80]), .cmd_feat_prev(cmd_f[79:72]), .cmd_cnt_cur(cmd_f[71:64]),
    .cmd_cnt_prev(cmd_f[63:56]), .cmd_secn_cur(cmd_f[55:48]), .cmd_secn_prev(cmd_f[47:40]),
    .cmd_cyll_cur(cmd_f[39:32]), .cmd_cyll_prev(cmd_f[31:24]), .cmd_cylh_cur(cmd_f[23:16]),
    .cmd_cylh_prev(cmd_f[15:8]), .cmd_devhead(cmd_f[7:0]), .wlog_valid, .wlog_ready, .wlog_tag,
    .wlog_count, .wlog_lba, .done_valid, .done_tag, .sdb_valid, .sdb_ready, .sdb_act, .d2h_valid,
    .d2h_ready, .d2h_error, .d2h_status, .command_error_flags(cef), .device_condition_flags(dcf));
  qsd_host_model i_host (.core_clk, .reset_n, .stall, .sdb_valid, .sdb_ready, .d2h_valid,
    .d2h_ready, .cmd_valid, .cmd_ready, .cmd_f);

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_for(ref logic s);
    for (int i = 0; i < 20 && s !== 1'b1; i++) @(negedge core_clk);
    // A wait that runs out is a failure in its own right
    if (s !== 1'b1) begin
      mismatches++;
      $display("MISMATCH wait exp 1 got %b", s);
    end
  endtask : wait_for
  function automatic logic [47:0] lba_of(input logic [4:0] t);
    return 48'h9a8b7c6d5e40 | t;
  endfunction : lba_of
  task automatic pop(input logic [4:0] t, input logic [7:0] fc);
    wait_for(wlog_valid);
    chk("wlog_tag", t, wlog_tag);
    chk("wlog_count", {8'ha5, fc}, wlog_count);
    chk("wlog_lba", lba_of(t), wlog_lba);
    wlog_ready = 1'b1;
    @(negedge core_clk);
    wlog_ready = 1'b0;
  endtask : pop
  task automatic complete(input logic [4:0] t, input logic [31:0] act);
    done_valid = 1'b1;
    done_tag = t;
    @(negedge core_clk);
    done_valid = 1'b0;
    wait_for(sdb_valid);
    chk("sdb_act", act, sdb_act);
    @(negedge core_clk);
  endtask : complete
  task automatic rej;
    wait_for(d2h_valid);
    chk("d2h_err", 8'h04, d2h_error & 8'h04);
    chk("d2h_stat", 8'h01, d2h_status & 8'h81);
    @(negedge core_clk);
  endtask : rej
  task automatic run(input qsd_row_t r);
    i_host.issue(8'h64, r.fc, {r.tg, 3'h5}, r.dh, lba_of(r.tg));
    if (r.ok) begin
      pop(r.tg, r.fc);
      complete(r.tg, 32'h1 << r.tg);
      chk("err_flags", 8'h00, cef);
    end else rej();
  endtask : run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Hang guard, about thirty times the expected run
  initial begin
    #(25 * 4000);
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    chk("reset", 20'h80040, {cmd_ready, wlog_valid, sdb_valid, d2h_valid, cef, dcf});
    $display("test reset done");
    foreach (rows[i]) run(rows[i]);
    for (int s = 0; s < 16; s++) run({4'h0, s[3:0], 8'h40, 5'(s + 8), s == 2});
    $display("test decode done");
    i_host.issue(8'h65, 8'h02, 8'h08, 8'h40, lba_of(5'd1));
    repeat (6) @(negedge core_clk);
    chk("foreign", 3'h4, {cmd_ready, wlog_valid, d2h_valid});
    $display("test foreign done");
    // Stalled drain: third word waits, no word lost
    for (int t = 5; t < 8; t++) i_host.issue(8'h64, 8'h02, {5'(t), 3'h0}, 8'h40, lba_of(5'(t)));
    repeat (3) @(negedge core_clk);
    chk("cmd_ready", 1'b0, cmd_ready);
    for (int t = 5; t < 8; t++) pop(5'(t), 8'h02);
    stall = 4'h3;
    done_valid = 1'b1;
    done_tag = 5'd5;
    @(negedge core_clk);
    complete(5'd6, 32'h60);
    stall = 4'h0;
    complete(5'd7, 32'h80);
    $display("test buffer done");
    stall = 4'h2;
    i_host.issue(8'h64, 8'h02, 8'h48, 8'h40, lba_of(5'd9));
    pop(5'd9, 8'h02);
    i_host.issue(8'h64, 8'h02, 8'h48, 8'h40, lba_of(5'd9));
    rej();
    repeat (4) @(negedge core_clk);
    complete(5'd9, 32'h200);
    $display("test outstanding done");
    // Reset while an error frame and a completion frame still wait
    stall = 4'hf;
    i_host.issue(8'h64, 8'h02, 8'h60, 8'h00, lba_of(5'd12));
    wait_for(d2h_valid);
    reset_n = 1'b0;
    @(negedge core_clk);
    chk("reset_mid", 20'h80040, {cmd_ready, wlog_valid, sdb_valid, d2h_valid, cef, dcf});
    chk("reset_act", 32'h0, sdb_act);
    chk("reset_d2h", 8'h40, d2h_status);
    reset_n = 1'b1;
    stall = 4'h0;
    run(rows[0]);
    $display("test reset mid-run done");
    end_sim();
  end
endmodule : qsd_send_decoder_tb

bind qsd_send_decoder qsd_send_decoder_asserts i_chk (.core_clk, .reset_n, .cmd_valid, .cmd_ready,
  .cmd_opcode, .cmd_feat_cur, .done_valid, .done_tag, .sdb_valid, .sdb_ready, .sdb_act, .d2h_valid,
  .d2h_ready, .d2h_error, .d2h_status, .command_error_flags, .device_condition_flags);

`default_nettype wire
